/* hw/cml_consts.svh */
// Register offsets, field positions, reset values and CRC constants
`ifndef CML_CONSTS_SVH
`define CML_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CML_OFS_DBG_ADDR 8'h00
`define CML_OFS_PTR_HI 8'h01
`define CML_OFS_PTR_LO 8'h02
`define CML_OFS_DATA 8'h03
`define CML_OFS_MSTAT 8'h04
`define CML_OFS_CKS0 8'h05
`define CML_OFS_CKS1 8'h06
`define CML_OFS_CKS2 8'h07
`define CML_OFS_CKS3 8'h08
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CML_BUSY_BIT 0
`define CML_READ_LOCK_INDICATOR_BIT 0
`define CML_WRITE_LOCK_INDICATOR_BIT 1
`define CML_ERR_BIT 2
`define CML_SEC_WR_MSB 7
`define CML_SEC_WR_LSB 4
`define CML_SEC_RD_MSB 3
`define CML_SEC_RD_LSB 0
// ----------------------------------------
// Reset values and CRC constants
// ----------------------------------------
`define CML_SEC_RST 8'h00
`define CML_BLOCK_LAST 8'hff
`define CML_CRC16_POLY 16'h1021
`define CML_CRC32_POLY 32'h04c11db7
`define CML_CRC16_INIT 16'hffff
`define CML_CRC32_INIT 32'hffffffff
`endif

/* hw/cml_pkg.sv */
// Types shared by the code memory lock and CRC block
package cml_pkg;
    // Engine state, one-hot
    typedef enum logic [4:0] {
        CML_ST_INIT_RD = 5'b00001,
        CML_ST_INIT_WT = 5'b00010,
        CML_ST_IDLE = 5'b00100,
        CML_ST_RUN = 5'b01000,
        CML_ST_DRAIN = 5'b10000
    } cml_state_e;
    // Write request towards code memory
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] data;
    } cml_mem_wr_s;
endpackage

/* hw/cml_lock_crc.sv */
// Code memory security lock and CRC engine behind a register port
// Functional notes
// - Any upper security bit zero blocks writes
// - Any lower security bit zero blocks reads
// - Status shows lock bits for pointed location
// - Write lock can never be removed; a read lock alone is undone by rewriting the security byte and resetting
// - CRC works even when fully locked
// - Block CRC covers aligned 256 bytes only
// - Second checksum write starts full CRC
// - Busy flag set while CRC runs
// - Full CRC result in bytes three..zero
// - Full CRC polynomial 0x04C11DB7
// - First checksum write gives block high byte
// - Block CRC result in bytes one..zero
// - Block CRC polynomial 0x1021
// - Allowed data port access advances pointer by one; a refused one leaves it
//
// Design decisions made here: the address map and strobed register access.
`include "cml_consts.svh"
module cml_lock_crc
    import cml_pkg::*;
#(
    parameter int MEM_BYTES = 8192,
    parameter logic [15:0] SEC_ADDR = 16'h1fff
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Code memory read port, data one cycle after address
    output logic [15:0] o_mem_addr,
    output logic o_mem_rd,
    input wire logic [7:0] i_mem_rdata,
    // Code memory write port
    output cml_mem_wr_s o_mem_wr
);
    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (MEM_BYTES < 256 || MEM_BYTES > 65536 || (MEM_BYTES % 256) != 0) begin : g_chk
        $error("MEM_BYTES must be a multiple of 256 between 256 and 65536");
    end

    localparam logic [15:0] LAST_ADDR = 16'(MEM_BYTES - 1);

    // ----------------------------------------
    // CRC step functions, one byte, MSB first
    // ----------------------------------------
    function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ `CML_CRC16_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic [31:0] crc32_step(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[31] ^ d[i]) ? ((r << 1) ^ `CML_CRC32_POLY) : (r << 1);
        end
        return r;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    cml_state_e state_r, state_nxt;  // Engine state
    logic [7:0] sec_r;               // Latched security byte
    logic [15:0] ptr_r;              // Memory location pointer
    logic [15:0] crc_addr_r;         // Next address the engine reads
    logic [15:0] end_addr_r;         // Last address of current CRC
    logic mode32_r;                  // Full memory CRC running
    logic vld_r;                     // Memory data of engine valid now
    logic [15:0] crc16_r;            // Block CRC accumulator
    logic [31:0] crc32_r;            // Full CRC accumulator
    logic [7:0] cks_r [4];           // Checksum byte registers
    logic err_r;                     // Sticky refused access flag
    logic dp_q_r;                    // Data port read answered now
    logic dp_ok_q_r;                 // That read was allowed
    logic [7:0] rdata_r;             // Registered read data

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire busy = (state_r != CML_ST_IDLE);
    wire wr_locked = ~&sec_r[`CML_SEC_WR_MSB:`CML_SEC_WR_LSB];
    wire rd_locked = ~&sec_r[`CML_SEC_RD_MSB:`CML_SEC_RD_LSB];
    wire in_range = (ptr_r <= LAST_ADDR);
    wire rd_ind = rd_locked & in_range;
    wire wr_ind = wr_locked & in_range;
    wire wr_dp = i_wr && i_addr == `CML_OFS_DATA;
    wire rd_dp = i_rd && i_addr == `CML_OFS_DATA;
    // The engine owns the memory while busy, so data port traffic is refused then
    wire dp_wr_ok = wr_dp && !busy && !wr_locked;
    wire dp_rd_ok = rd_dp && !busy && !rd_locked;
    wire dp_refused = (wr_dp || rd_dp) && !(dp_wr_ok || dp_rd_ok);
    wire start16 = i_wr && i_addr == `CML_OFS_CKS0 && !busy;
    wire start32 = i_wr && i_addr == `CML_OFS_CKS1 && !busy;
    wire [15:0] crc16_nxt = crc16_step(crc16_r, i_mem_rdata);
    wire [31:0] crc32_nxt = crc32_step(crc32_r, i_mem_rdata);
    wire [7:0] mstat_val = {5'h00, err_r, wr_ind, rd_ind};
    wire [7:0] rd_mux =
        (i_addr == `CML_OFS_DBG_ADDR) ? {7'h00, busy} :
        (i_addr == `CML_OFS_PTR_HI) ? ptr_r[15:8] :
        (i_addr == `CML_OFS_PTR_LO) ? ptr_r[7:0] :
        (i_addr == `CML_OFS_MSTAT) ? mstat_val :
        (i_addr == `CML_OFS_CKS0) ? cks_r[0] :
        (i_addr == `CML_OFS_CKS1) ? cks_r[1] :
        (i_addr == `CML_OFS_CKS2) ? cks_r[2] :
        (i_addr == `CML_OFS_CKS3) ? cks_r[3] : 8'h00;

    // Engine reads by its own address, otherwise the pointer is presented
    assign o_mem_addr = busy ? crc_addr_r : ptr_r;
    assign o_mem_rd = (state_r == CML_ST_RUN) || (state_r == CML_ST_INIT_RD) || dp_rd_ok;
    // A refused read returns zero rather than memory contents
    assign o_rdata = dp_q_r ? (dp_ok_q_r ? i_mem_rdata : 8'h00) : rdata_r;

    // ----------------------------------------
    // State machine
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CML_ST_INIT_RD: state_nxt = CML_ST_INIT_WT;
            CML_ST_INIT_WT: state_nxt = CML_ST_IDLE;
            CML_ST_IDLE: begin
                // Lock state does not gate starts: verification stays possible
                if (start16 || start32) begin
                    state_nxt = CML_ST_RUN;
                end
            end
            CML_ST_RUN: begin
                if (crc_addr_r == end_addr_r) begin
                    state_nxt = CML_ST_DRAIN;
                end
            end
            CML_ST_DRAIN: state_nxt = CML_ST_IDLE;
            default: state_nxt = CML_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_r <= CML_ST_INIT_RD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------
    // Security byte: loaded after reset, bits may only clear
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sec_r <= `CML_SEC_RST; // Locked until the real byte is read
        end else if (state_r == CML_ST_INIT_WT) begin
            sec_r <= i_mem_rdata;
        end else if (dp_wr_ok && ptr_r == SEC_ADDR) begin
            sec_r <= sec_r & i_wdata;
        end
    end

    // ----------------------------------------
    // Location pointer
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ptr_r <= 16'h0000;
        end else if (dp_wr_ok || dp_rd_ok) begin
            ptr_r <= ptr_r + 16'h0001;
        end else if (i_wr && !busy && i_addr == `CML_OFS_PTR_HI) begin
            ptr_r[15:8] <= i_wdata;
        end else if (i_wr && !busy && i_addr == `CML_OFS_PTR_LO) begin
            ptr_r[7:0] <= i_wdata;
        end
    end

    // ----------------------------------------
    // Memory write port
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_mem_wr <= '0;
        end else begin
            o_mem_wr <= '{we: dp_wr_ok, addr: ptr_r, data: i_wdata};
        end
    end

    // ----------------------------------------
    // Engine address walk
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            crc_addr_r <= SEC_ADDR;
            end_addr_r <= 16'h0000;
            mode32_r <= 1'b0;
        end else if (start16) begin
            crc_addr_r <= {i_wdata, 8'h00};
            end_addr_r <= {i_wdata, `CML_BLOCK_LAST};
            mode32_r <= 1'b0;
        end else if (start32) begin
            crc_addr_r <= 16'h0000;
            end_addr_r <= LAST_ADDR;
            mode32_r <= 1'b1;
        end else if (state_r == CML_ST_RUN && crc_addr_r != end_addr_r) begin
            crc_addr_r <= crc_addr_r + 16'h0001;
        end
    end

    // ----------------------------------------
    // CRC accumulators and result bytes
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            vld_r <= 1'b0;
            crc16_r <= `CML_CRC16_INIT;
            crc32_r <= `CML_CRC32_INIT;
            cks_r <= '{default: 8'h00};
        end else begin
            vld_r <= (state_r == CML_ST_RUN);
            if (start16 || start32) begin
                crc16_r <= `CML_CRC16_INIT;
                crc32_r <= `CML_CRC32_INIT;
            end else if (vld_r) begin
                crc16_r <= crc16_nxt;
                crc32_r <= crc32_nxt;
            end
            if (state_r == CML_ST_DRAIN && mode32_r) begin
                cks_r[3] <= crc32_nxt[31:24];
                cks_r[2] <= crc32_nxt[23:16];
                cks_r[1] <= crc32_nxt[15:8];
                cks_r[0] <= crc32_nxt[7:0];
            end else if (state_r == CML_ST_DRAIN) begin
                cks_r[1] <= crc16_nxt[15:8];
                cks_r[0] <= crc16_nxt[7:0];
            end
        end
    end

    // ----------------------------------------
    // Read data and error flag
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rdata_r <= 8'h00;
            dp_q_r <= 1'b0;
            dp_ok_q_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            rdata_r <= i_rd ? rd_mux : 8'h00;
            dp_q_r <= rd_dp;
            dp_ok_q_r <= dp_rd_ok;
            // A new refusal wins over a clear in the same cycle
            if (dp_refused) begin
                err_r <= 1'b1;
            end else if (i_wr && i_addr == `CML_OFS_MSTAT) begin
                err_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_wr_lock_block: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (wr_dp && wr_locked) |=> !o_mem_wr.we)
        else $error("write passed while write locked");

    a_rd_lock_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (rd_dp && rd_locked) |=> (o_rdata == 8'h00 && !$past(o_mem_rd && !busy)))
        else $error("read data leaked while read locked");

    a_mstat_lock_bits: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_rd && i_addr == `CML_OFS_MSTAT && !i_wr) |=>
        (o_rdata[`CML_READ_LOCK_INDICATOR_BIT] == $past(rd_ind) && o_rdata[`CML_WRITE_LOCK_INDICATOR_BIT] == $past(wr_ind)))
        else $error("status lock bits do not match lock state");

    a_lock_no_undo: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_r != CML_ST_INIT_WT) |=> ((sec_r & ~$past(sec_r)) == 8'h00))
        else $error("security bit returned to one");

    a_start_when_locked: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (start32 && wr_locked && rd_locked) |=> (state_r == CML_ST_RUN))
        else $error("engine refused start while locked");

    a_block_aligned: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_r == CML_ST_RUN && !mode32_r) |->
        (end_addr_r[7:0] == 8'hff && end_addr_r[15:8] == crc_addr_r[15:8]))
        else $error("block walk outside aligned 256 bytes");

    a_busy_block_len: assert property (@(posedge i_clk) disable iff (!i_rstn)
        start16 |=> busy [*8] ##249 busy ##1 !busy)
        else $error("block CRC busy time is not 257 cycles");

    a_busy_ignore: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (busy && state_r != CML_ST_DRAIN && i_wr &&
        (i_addr == `CML_OFS_CKS0 || i_addr == `CML_OFS_CKS1)) |=>
        ($stable(end_addr_r) && $stable(mode32_r)))
        else $error("start write disturbed a running CRC");

    a_ptr_advance: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (dp_rd_ok || dp_wr_ok) |=> (ptr_r == $past(ptr_r) + 16'h0001))
        else $error("pointer did not advance after data access");

    // The accumulator must have folded in the last byte before the result is shown
    a_full_result: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_r == CML_ST_DRAIN && mode32_r) |=>
        ({cks_r[3], cks_r[2], cks_r[1], cks_r[0]} == crc32_r))
        else $error("full CRC result not placed in checksum bytes");

    // Results stand until the next CRC completes
    a_cks_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_r != CML_ST_DRAIN) |=>
        ($stable(cks_r[0]) && $stable(cks_r[1]) && $stable(cks_r[2]) && $stable(cks_r[3])))
        else $error("checksum bytes changed outside completion");

endmodule

/* bench/cml_code_mem.sv */
// Code memory model seen by the lock and CRC block
module cml_code_mem
    import cml_pkg::*;
#(
    parameter int MEM_BYTES = 512
) (
    // Clock
    input wire logic i_clk,
    // Read port, data one cycle after the address
    input wire logic [15:0] i_addr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Write port
    input wire cml_mem_wr_s i_wr
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] mem [MEM_BYTES]; // Filled by the bench at time zero
    initial o_rdata = 8'h00;
    // Registered read; an idle port inverts its output each cycle, so stale data shows again every second idle cycle
    always @(posedge i_clk) begin
        if (i_rd) begin
            o_rdata <= mem[i_addr % MEM_BYTES];
        end else begin
            o_rdata <= ~o_rdata;
        end
        if (i_wr.we) begin
            mem[i_wr.addr % MEM_BYTES] <= i_wr.data;
        end
    end
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the code memory lock and CRC block
module tb_top
    import cml_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Signals and model state
    // ----------------------------------------
    localparam int MB = 512; // Small memory keeps the full CRC short
    localparam logic [15:0] SA = 16'h01ff; // Security byte at the top
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic [15:0] o_mem_addr;
    logic o_mem_rd;
    logic [7:0] i_mem_rdata;
    cml_mem_wr_s o_mem_wr;
    logic [7:0] mm [MB]; // Expected memory contents
    int fail_count = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'd25;
    logic [7:0] d0, d1;
    always #10 i_clk = ~i_clk;
    cml_lock_crc #(.MEM_BYTES(MB), .SEC_ADDR(SA)) i_cml_lock_crc (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mem_addr(o_mem_addr),
        .o_mem_rd(o_mem_rd), .i_mem_rdata(i_mem_rdata), .o_mem_wr(o_mem_wr));
    cml_code_mem #(.MEM_BYTES(MB)) i_cml_code_mem (
        .i_clk(i_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd),
        .o_rdata(i_mem_rdata), .i_wr(o_mem_wr));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Reference CRCs: all-ones start, bytes MSB first, no final xor
    function automatic logic [31:0] crc(int base, int len, bit wide);
        logic [31:0] c;
        logic fb;
        c = wide ? 32'hffffffff : 32'h0000ffff;
        for (int i = 0; i < len; i++) begin
            for (int b = 7; b >= 0; b--) begin
                fb = (wide ? c[31] : c[15]) ^ mm[base + i][b];
                c = c << 1;
                if (fb) c ^= wide ? 32'h04c11db7 : 32'h00001021;
                if (!wide) c[31:16] = 16'h0000;
            end
        end
        return c;
    endfunction
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus cycle, entered just after a rising edge; a gap cycle follows
    task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        #1 q = o_rdata;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic set_ptr(input logic [15:0] p);
        wr(8'h01, p[15:8]);
        wr(8'h02, p[7:0]);
    endtask
    // Poll the busy flag with a bounded count
    task automatic poll();
        logic [7:0] q;
        for (int n = 0; n < 1000; n++) begin
            bus(1'b0, 8'h00, 8'h00, q);
            if (q[0] === 1'b0) return;
        end
        fail_count++;
        conclude();
    endtask
    task automatic do_reset();
        i_rstn <= 1'b0;
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_clk);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        for (int k = 0; k < MB; k++) begin
            mm[k] = rnd();
            i_cml_code_mem.mem[k] = mm[k];
        end
        mm[SA] = 8'hff; // Unlocked at start
        i_cml_code_mem.mem[SA] = 8'hff;
        do_reset();
        rdc(8'h00, 8'h00);
        rdc(8'h20, 8'h00);
        rdc(8'h04, 8'h00);
        // Two data-port writes, then read them back through the pointer
        d0 = rnd();
        d1 = rnd();
        set_ptr(16'h0010);
        wr(8'h03, d0);
        wr(8'h03, d1);
        mm[16] = d0;
        mm[17] = d1;
        set_ptr(16'h0010);
        rdc(8'h03, d0);
        rdc(8'h03, d1);
        // Block CRC on block 1; a second start while busy must be ignored
        wr(8'h05, 8'h01);
        rdc(8'h00, 8'h01);
        wr(8'h05, 8'h00);
        poll();
        rdc(8'h00, 8'h00);
        rdc(8'h05, crc(256, 256, 1'b0) & 8'hff);
        rdc(8'h06, crc(256, 256, 1'b0) >> 8);
        // Read lock only
        set_ptr(SA);
        wr(8'h03, 8'hf7);
        mm[SA] = 8'hf7;
        set_ptr(16'h0000);
        rdc(8'h04, 8'h01);
        rdc(8'h03, 8'h00);
        rdc(8'h04, 8'h05);
        wr(8'h04, 8'h00);
        // Add write lock, then try to write and to unlock
        set_ptr(SA);
        wr(8'h03, 8'h77);
        mm[SA] = 8'h77;
        set_ptr(16'h0000);
        rdc(8'h04, 8'h03);
        wr(8'h03, ~mm[0]);
        rdc(8'h04, 8'h07);
        set_ptr(SA);
        wr(8'h03, 8'hff);
        wr(8'h07, 8'h5a);
        // Block CRC over block 0 while fully locked proves the write to address 0 was refused
        wr(8'h05, 8'h00);
        poll();
        rdc(8'h05, crc(0, 256, 1'b0) & 8'hff);
        rdc(8'h06, crc(0, 256, 1'b0) >> 8);
        // Reset between block and full CRC; lock survives the reset
        do_reset();
        set_ptr(16'h0000);
        rdc(8'h04, 8'h03);
        wr(8'h06, rnd());
        poll();
        rdc(8'h05, crc(0, MB, 1'b1) & 8'hff);
        rdc(8'h06, (crc(0, MB, 1'b1) >> 8) & 8'hff);
        rdc(8'h07, (crc(0, MB, 1'b1) >> 16) & 8'hff);
        rdc(8'h08, crc(0, MB, 1'b1) >> 24);
        conclude();
    end
endmodule
